// *** inc/arith_map.vh ***
// Register map, field positions, operation codes and timing counts of the arithmetic datapath.
// Assumes inclusion by bare name from the design files.
`ifndef ARITH_MAP_VH
`define ARITH_MAP_VH
// ----------------------------------------------------------------
// Register bus map
// ----------------------------------------------------------------
`define ADDR_CPU_CONTROL  4'h0
`define ADDR_ARITH_STATUS 4'h4
`define ADDR_OP_A         4'h8
`define ADDR_OP_B         4'hc
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_PRIO_HIGH_BIT 3
`define CTL_PWIN_BIT      2
`define CTL_RESET         16'h0000
`define SR_RESET          16'h0000
`define SR_C_BIT          0
`define SR_Z_BIT          1
`define SR_OV_BIT         2
`define SR_N_BIT          3
`define SR_DC_BIT         8
`define SR_IPL_LSB        5
`define SR_IPL_MSB        7
`define SR_WMASK          16'h01ef
`define PRIO_USER_MAX     4'h7
// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_ADD  4'h0
`define OP_SUB  4'h1
`define OP_AND  4'h2
`define OP_IOR  4'h3
`define OP_XOR  4'h4
`define OP_ASR  4'h5
`define OP_SL   4'h6
`define OP_LSR  4'h7
`define OP_MUL  4'h8
`define OP_DIV  4'h9
`define MUL_SS  3'h0
`define MUL_UU  3'h1
`define MUL_SU  3'h2
`define MUL_US  3'h3
`define MUL_SL5 3'h4
`define MUL_UL5 3'h5
`define MUL_B8  3'h6
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DIV_CYCLES 5'd19
`define DIV_BITS   5'd16
`define W_ZERO     4'h0
`define W_ONE      4'h1
`endif

// *** rtl/mult17.v ***
// Signed 17x17 multiplier array shared by every multiply mode.
// Assumes the caller sign- or zero-extends each operand to 17 bits.
`default_nettype none
module mult17 (
    // Operands
    input  wire signed [16:0] a,
    input  wire signed [16:0] b,
    // Product
    output wire        [33:0] p
);
    wire signed [33:0] prod;
    assign prod = a * b;
    assign p    = prod;
endmodule // mult17
`default_nettype wire

// *** rtl/arith_datapath.v ***
// Arithmetic datapath: adder and logic unit with flags, multiplier, iterative divider,
// barrel shifter and the cpu control register, reached over AXI4-Lite.
// Assumes a decoder that presents one operation with a start pulse and waits for done.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`include "arith_map.vh"
`default_nettype none
module arith_datapath (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [3:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [3:0]  s_axi_araddr,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Operation request from the decoder
    input  wire        op_start,
    input  wire [3:0]  op_code,
    input  wire        op_byte,
    input  wire        op_signed,
    input  wire        op_long,
    input  wire [2:0]  mul_mode,
    input  wire [3:0]  shift_amount,
    input  wire        src_is_mem,
    input  wire        dst_is_mem,
    input  wire [3:0]  src_reg,
    input  wire [3:0]  div_reg,
    input  wire [15:0] mem_rdata,
    input  wire [15:0] wreg_rdata_a,
    input  wire [15:0] wreg_rdata_b,
    input  wire [15:0] wreg_rdata_hi,
    // Interrupt side
    input  wire        interrupt_pending,
    input  wire [3:0]  interrupt_priority,
    input  wire        interrupt_break,
    // Results
    output reg         op_done,
    output reg         op_illegal,
    output reg  [15:0] result,
    output reg  [15:0] result_hi,
    output reg         wreg_we,
    output reg  [3:0]  wreg_waddr,
    output reg         wreg_we2,
    output reg  [3:0]  wreg_waddr2,
    output reg         mem_we,
    output wire        div_busy,
    // Control outputs
    output wire        program_window_enable,
    output wire [3:0]  processor_priority_level,
    output wire        interrupt_take
);
    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_DIV  = 2'b10;
    reg  [15:0] cpu_control_q;
    reg  [15:0] arith_status_reg_q;
    reg  [15:0] op_a_q;
    reg  [15:0] op_b_q;
    reg  [1:0]  state_q;
    reg  [4:0]  div_cnt_q;
    reg  [31:0] div_rem_q;
    reg  [15:0] div_quot_q;
    reg  [15:0] div_dvs_q;
    reg         div_negq_q;
    reg         div_negr_q;
    reg         aw_seen_q;
    reg         w_seen_q;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    wire        bus_wr;
    wire        priority_high_bit;
    assign priority_high_bit        = cpu_control_q[`CTL_PRIO_HIGH_BIT];
    assign program_window_enable    = cpu_control_q[`CTL_PWIN_BIT];
    assign processor_priority_level = {priority_high_bit,
        arith_status_reg_q[`SR_IPL_MSB:`SR_IPL_LSB]};
    assign interrupt_take = interrupt_pending && !priority_high_bit
        && (interrupt_priority > processor_priority_level)
        && (interrupt_priority <= `PRIO_USER_MAX);
    assign div_busy = (state_q == ST_DIV);
    // ----------------------------------------------------------------
    // Operand selection
    // ----------------------------------------------------------------
    wire [15:0] opnd_a;
    wire [15:0] opnd_b;
    assign opnd_a = src_is_mem ? mem_rdata : wreg_rdata_a;
    assign opnd_b = wreg_rdata_b;
    // ----------------------------------------------------------------
    // Adder and logic unit
    // ----------------------------------------------------------------
    reg  [15:0] alu_res;
    reg         alu_c;
    reg         alu_dc;
    reg         alu_ov;
    reg         flags_upd;
    reg  [16:0] sum;
    reg  [8:0]  low9;
    reg  [4:0]  low5;
    reg  [15:0] bsub;
    reg         cin;
    always @* begin
        bsub = (op_code == `OP_SUB) ? ~opnd_b : opnd_b;
        cin  = (op_code == `OP_SUB);
        sum  = {1'b0, opnd_a} + {1'b0, bsub} + {16'h0000, cin};
        low9 = {1'b0, opnd_a[7:0]} + {1'b0, bsub[7:0]} + {8'h00, cin};
        low5 = {1'b0, opnd_a[3:0]} + {1'b0, bsub[3:0]} + {4'h0, cin};
        alu_res   = 16'h0000;
        alu_c     = 1'b0;
        alu_dc    = 1'b0;
        alu_ov    = 1'b0;
        flags_upd = 1'b1;
        case (op_code)
            `OP_ADD, `OP_SUB: begin
                alu_res = sum[15:0];
                // The inverted-operand adder gives carry = no borrow directly.
                alu_c   = op_byte ? low9[8] : sum[16];
                alu_dc  = op_byte ? low5[4] : low9[8];
                alu_ov  = op_byte ?
                    (opnd_a[7] == bsub[7]) && (sum[7] != opnd_a[7]) :
                    (opnd_a[15] == bsub[15]) && (sum[15] != opnd_a[15]);
            end
            `OP_AND: alu_res = opnd_a & opnd_b;
            `OP_IOR: alu_res = opnd_a | opnd_b;
            `OP_XOR: alu_res = opnd_a ^ opnd_b;
            default: flags_upd = 1'b0;
        endcase
    end
    // ----------------------------------------------------------------
    // Barrel shifter
    // ----------------------------------------------------------------
    reg  [15:0] sh_res;
    reg         sh_c;
    wire [31:0] sh_ext;
    assign sh_ext = {{16{wreg_rdata_a[15]}}, wreg_rdata_a};
    always @* begin
        sh_res = 16'h0000;
        sh_c   = 1'b0;
        case (op_code)
            `OP_ASR: begin
                sh_res = sh_ext[shift_amount +: 16];
                sh_c   = (shift_amount == 4'h0) ? 1'b0 : wreg_rdata_a[shift_amount - 4'h1];
            end
            `OP_SL: begin
                sh_res = wreg_rdata_a << shift_amount;
                sh_c   = (shift_amount == 4'h0) ? 1'b0 :
                    wreg_rdata_a[4'hf - shift_amount + 4'h1];
            end
            `OP_LSR: begin
                sh_res = wreg_rdata_a >> shift_amount;
                sh_c   = (shift_amount == 4'h0) ? 1'b0 : wreg_rdata_a[shift_amount - 4'h1];
            end
            default: sh_res = 16'h0000;
        endcase
    end
    wire is_shift;
    assign is_shift = (op_code == `OP_ASR) || (op_code == `OP_SL) || (op_code == `OP_LSR);
    // ----------------------------------------------------------------
    // Multiplier operand shaping
    // ----------------------------------------------------------------
    reg  [16:0] mul_a;
    reg  [16:0] mul_b;
    wire [33:0] mul_p;
    always @* begin
        mul_a = {1'b0, opnd_a};
        mul_b = {1'b0, opnd_b};
        case (mul_mode)
            `MUL_SS:  begin
                mul_a = {opnd_a[15], opnd_a};
                mul_b = {opnd_b[15], opnd_b};
            end
            `MUL_SU:  mul_a = {opnd_a[15], opnd_a};
            `MUL_US:  mul_b = {opnd_b[15], opnd_b};
            `MUL_SL5: begin
                mul_a = {opnd_a[15], opnd_a};
                mul_b = {12'h000, shift_amount[3:0], op_long};
            end
            `MUL_UL5: mul_b = {12'h000, shift_amount[3:0], op_long};
            `MUL_B8:  begin
                mul_a = {9'h000, opnd_a[7:0]};
                mul_b = {9'h000, opnd_b[7:0]};
            end
            default:  mul_b = {1'b0, opnd_b};
        endcase
    end
    mult17 u_mult (
        .a (mul_a),
        .b (mul_b),
        .p (mul_p)
    );
    // ----------------------------------------------------------------
    // Divider step, restoring form on magnitudes
    // ----------------------------------------------------------------
    wire [31:0] dvd_raw;
    wire        dvd_neg;
    wire        dvs_neg;
    wire [31:0] dvd_mag;
    wire [15:0] dvs_mag;
    wire [16:0] trial;
    assign dvd_raw = op_long ? {wreg_rdata_hi, wreg_rdata_a} :
        (op_signed ? {{16{wreg_rdata_a[15]}}, wreg_rdata_a} : {16'h0000, wreg_rdata_a});
    assign dvd_neg = op_signed && dvd_raw[31];
    assign dvs_neg = op_signed && wreg_rdata_b[15];
    assign dvd_mag = dvd_neg ? (~dvd_raw + 32'h00000001) : dvd_raw;
    assign dvs_mag = dvs_neg ? (~wreg_rdata_b + 16'h0001) : wreg_rdata_b;
    assign trial   = div_rem_q[31:15] - {1'b0, div_dvs_q};
    // ----------------------------------------------------------------
    // Operation sequencing
    // ----------------------------------------------------------------
    wire [15:0] res_w;
    assign res_w = is_shift ? sh_res : alu_res;
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q            <= ST_IDLE;
            div_cnt_q          <= 5'd0;
            div_rem_q          <= 32'h00000000;
            div_quot_q         <= 16'h0000;
            div_dvs_q          <= 16'h0000;
            div_negq_q         <= 1'b0;
            div_negr_q         <= 1'b0;
            op_done            <= 1'b0;
            op_illegal         <= 1'b0;
            result             <= 16'h0000;
            result_hi          <= 16'h0000;
            wreg_we            <= 1'b0;
            wreg_waddr         <= 4'h0;
            wreg_we2           <= 1'b0;
            wreg_waddr2        <= 4'h0;
            mem_we             <= 1'b0;
            arith_status_reg_q <= `SR_RESET;
        end else begin
            op_done    <= 1'b0;
            op_illegal <= 1'b0;
            wreg_we    <= 1'b0;
            wreg_we2   <= 1'b0;
            mem_we     <= 1'b0;
            if (bus_wr && aw_addr_q == `ADDR_ARITH_STATUS && w_strb_q[0]) begin
                arith_status_reg_q <= w_data_q[15:0] & `SR_WMASK;
            end
            case (state_q)
                ST_IDLE: begin
                    if (op_start && op_code == `OP_DIV) begin
                        state_q    <= ST_DIV;
                        div_cnt_q  <= `DIV_CYCLES;
                        div_rem_q  <= dvd_mag;
                        div_quot_q <= 16'h0000;
                        div_dvs_q  <= dvs_mag;
                        div_negq_q <= dvd_neg ^ dvs_neg;
                        div_negr_q <= dvd_neg;
                    end else if (op_start && is_shift && (src_is_mem || dst_is_mem)) begin
                        op_done    <= 1'b1;
                        op_illegal <= 1'b1;
                    end else if (op_start) begin
                        op_done    <= 1'b1;
                        wreg_waddr <= src_reg;
                        wreg_we    <= !dst_is_mem;
                        mem_we     <= dst_is_mem;
                        if (op_code == `OP_MUL) begin
                            result    <= mul_p[15:0];
                            result_hi <= mul_p[31:16];
                        end else if (op_byte) begin
                            result    <= {opnd_a[15:8], res_w[7:0]};
                            result_hi <= 16'h0000;
                        end else begin
                            result    <= res_w;
                            result_hi <= 16'h0000;
                        end
                        if (flags_upd || is_shift) begin
                            arith_status_reg_q[`SR_C_BIT] <= is_shift ? sh_c : alu_c;
                            arith_status_reg_q[`SR_Z_BIT] <= op_byte ?
                                (res_w[7:0] == 8'h00) : (res_w == 16'h0000);
                            arith_status_reg_q[`SR_N_BIT] <= op_byte ? res_w[7] : res_w[15];
                            arith_status_reg_q[`SR_OV_BIT] <= is_shift ? 1'b0 : alu_ov;
                            if (!is_shift) begin
                                arith_status_reg_q[`SR_DC_BIT] <= alu_dc;
                            end
                        end
                    end
                end
                ST_DIV: begin
                    // Abort leaves work registers untouched so the decoder can retry.
                    if (interrupt_break) begin
                        state_q <= ST_IDLE;
                    end else begin
                        div_cnt_q <= div_cnt_q - 5'd1;
                        if (div_cnt_q <= `DIV_CYCLES && div_cnt_q > `DIV_CYCLES - `DIV_BITS) begin
                            if (!trial[16]) begin
                                div_rem_q  <= {trial[15:0], div_rem_q[14:0], 1'b0};
                                div_quot_q <= {div_quot_q[14:0], 1'b1};
                            end else begin
                                div_rem_q  <= {div_rem_q[30:0], 1'b0};
                                div_quot_q <= {div_quot_q[14:0], 1'b0};
                            end
                        end
                        if (div_cnt_q == 5'd2) begin
                            state_q     <= ST_IDLE;
                            op_done     <= 1'b1;
                            result      <= div_negq_q ? (~div_quot_q + 16'h0001) : div_quot_q;
                            result_hi   <= div_negr_q ? (~div_rem_q[31:16] + 16'h0001)
                                                      : div_rem_q[31:16];
                            wreg_we     <= 1'b1;
                            wreg_waddr  <= `W_ZERO;
                            wreg_we2    <= 1'b1;
                            wreg_waddr2 <= `W_ONE;
                            arith_status_reg_q[`SR_Z_BIT] <= (div_quot_q == 16'h0000);
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_seen_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_seen_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign bus_wr        = aw_seen_q && w_seen_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_seen_q     <= 1'b0;
            w_seen_q      <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
            cpu_control_q <= `CTL_RESET;
            op_a_q        <= 16'h0000;
            op_b_q        <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_seen_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_seen_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (bus_wr) begin
                aw_seen_q    <= 1'b0;
                w_seen_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AXI_RESP_OKAY;
                case (aw_addr_q)
                    `ADDR_CPU_CONTROL: if (w_strb_q[0]) begin
                        // Priority high bit can be cleared only, never set.
                        cpu_control_q[`CTL_PRIO_HIGH_BIT] <= priority_high_bit
                            & w_data_q[`CTL_PRIO_HIGH_BIT];
                        cpu_control_q[`CTL_PWIN_BIT] <= w_data_q[`CTL_PWIN_BIT];
                    end
                    `ADDR_ARITH_STATUS: s_axi_bresp <= `AXI_RESP_OKAY;
                    `ADDR_OP_A: op_a_q <= w_data_q[15:0];
                    `ADDR_OP_B: op_b_q <= w_data_q[15:0];
                    default: s_axi_bresp <= `AXI_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `AXI_RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_CPU_CONTROL:  s_axi_rdata <= {16'h0000, cpu_control_q};
                    `ADDR_ARITH_STATUS: s_axi_rdata <= {16'h0000, arith_status_reg_q};
                    `ADDR_OP_A:         s_axi_rdata <= {16'h0000, op_a_q};
                    `ADDR_OP_B:         s_axi_rdata <= {16'h0000, op_b_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AXI_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // arith_datapath
`default_nettype wire

// *** test/wreg_model.sv ***
// Working register file beside the datapath.
// Assumes the bench preloads r; dividend pair is 2/3, divisor 6.
`default_nettype none
module wreg_model (
    // Clock and write-back
    input  wire logic        aclk, we,
    input  wire logic [3:0]  wa,
    input  wire logic [15:0] wd,
    // Operand reads
    output logic      [15:0] rd_a, rd_b, rd_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] r [16];
    assign rd_a = r[2];
    assign rd_b = r[6];
    assign rd_hi = r[3];
    always @(posedge aclk) if (we) r[wa] <= wd;
endmodule // wreg_model
`default_nettype wire

// *** test/arith_datapath_asserts.sv ***
// Port assertions for the arithmetic datapath.
// Assumes one clock with synchronous active-low reset.
`include "arith_map.vh"
`default_nettype none
module arith_checker (
    // Request side
    input wire logic       aclk, aresetn, op_start, div_busy, mem_we,
    input wire logic [3:0] op_code, interrupt_priority, wreg_waddr,
    // Result side
    input wire logic       op_done, wreg_we, wreg_we2, interrupt_take,
    input wire logic [3:0] wreg_waddr2, processor_priority_level
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence div_go;
        op_start && !div_busy && op_code == `OP_DIV;
    endsequence
    sequence div_end;
        div_go ##19 op_done;
    endsequence
    prio_clear_a: assert property (!processor_priority_level[3])
        else $error("high bit set");
    irq_block_a: assert property (processor_priority_level[3] |-> !interrupt_take)
        else $error("take while blocked");
    take_cause_a: assert property (interrupt_take |->
        interrupt_priority > processor_priority_level) else $error("take too low");
    alu_answer_a: assert property (op_start && !div_busy && op_code != `OP_DIV
        |=> op_done) else $error("no done");
    div_len_a: assert property (div_go |-> ##19 (op_done || !div_busy))
        else $error("divide late");
    div_quiet_a: assert property (div_go |=> !op_done [*8])
        else $error("divide early");
    div_dest_a: assert property (div_end |-> wreg_we && wreg_waddr == `W_ZERO
        && wreg_we2 && wreg_waddr2 == `W_ONE) else $error("divide targets");
    strobe_done_a: assert property (wreg_we || mem_we |-> op_done)
        else $error("strobe alone");
endmodule // arith_checker
bind arith_datapath arith_checker u_chk (.aclk, .aresetn, .op_start, .div_busy, .mem_we,
    .op_code, .interrupt_priority, .wreg_waddr, .op_done, .wreg_we, .wreg_we2,
    .interrupt_take, .wreg_waddr2, .processor_priority_level);
`default_nettype wire

// *** test/test_cpu_arith_datapath.sv ***
// Self-checking bench for the arithmetic datapath.
// Assumes arith_map.vh on the include path and the checker bound in.
`include "arith_map.vh"
`default_nettype none
module test_cpu_arith_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, op_start = 0, op_byte = 0, op_signed = 0, op_long = 0;
    logic src_is_mem = 0, dst_is_mem = 0, interrupt_pending = 0, interrupt_break = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] op_code = 0, shift_amount = 0, src_reg = 4'h4, div_reg = 0, interrupt_priority = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [2:0] mul_mode = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [15:0] mem_rdata = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_done;
    wire logic op_illegal, wreg_we, wreg_we2, mem_we, div_busy, program_window_enable, interrupt_take;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [15:0] result, result_hi, wreg_rdata_a, wreg_rdata_b, wreg_rdata_hi;
    wire logic [3:0] wreg_waddr, wreg_waddr2, processor_priority_level;
    int n_errors = 0, num_checks = 0, cyc = 0;
    arith_datapath dut (.*);
    wreg_model m (.aclk(aclk), .we(wreg_we), .wa(wreg_waddr), .wd(result), .rd_a(wreg_rdata_a),
        .rd_b(wreg_rdata_b), .rd_hi(wreg_rdata_hi));
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin n_errors++; conclude(); end
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin n_errors++; $display("MISMATCH %s expected %h seen %h", nm, exp, seen); end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Handshakes are sampled at the falling edge.
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic ta = 0, tw = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk); ta |= s_axi_awready; tw |= s_axi_wready;
            @(posedge aclk); s_axi_awvalid <= !ta; s_axi_wvalid <= !tw;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        chk("bresp", s_axi_bresp, `AXI_RESP_OKAY);
        @(posedge aclk); s_axi_bready <= 0;
    endtask
    task automatic axr(input logic [3:0] a, input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk); s_axi_arvalid <= 0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata; chk("rresp", s_axi_rresp, er);
        @(posedge aclk); s_axi_rready <= 0;
    endtask
    task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [15:0] b,
                      input logic [31:0] exp, input int lat);
        int n = 0;
        logic ill;
        @(posedge aclk); ill = (c inside {`OP_ASR, `OP_SL, `OP_LSR}) && src_is_mem;
        m.r[2] <= src_is_mem ? ~a[15:0] : a[15:0]; m.r[3] <= a[31:16]; m.r[6] <= b;
        mem_rdata <= a[15:0]; op_code <= c; op_start <= 1;
        @(posedge aclk); op_start <= 0;
        do begin @(negedge aclk); n++; end while (!op_done && n < 30);
        chk("latency", n, lat);
        chk("illegal", op_illegal, ill);
        chk("mem write", mem_we, dst_is_mem && !ill);
        if (!ill) chk("result", {c >= `OP_MUL ? result_hi : 16'h0, result}, exp);
        @(posedge aclk);
    endtask
    task automatic t_regs();
        axr(`ADDR_CPU_CONTROL, `AXI_RESP_OKAY); chk("ctl reset", rd, 32'h0);
        axw(`ADDR_CPU_CONTROL, 32'hffff); axr(`ADDR_CPU_CONTROL, `AXI_RESP_OKAY);
        chk("ctl", rd, 32'h4);
        chk("window", program_window_enable, 1'b1);
        axw(`ADDR_CPU_CONTROL, 32'h0); axr(4'h2, `AXI_RESP_SLVERR);
        axw(`ADDR_ARITH_STATUS, 32'h60); interrupt_pending <= 1;
        for (int p = 2; p < 10; p++) begin
            interrupt_priority <= p[3:0];
            @(negedge aclk); chk("take", interrupt_take, p > 3 && p < 8);
            @(posedge aclk);
        end
        chk("level", processor_priority_level, 4'h3);
        interrupt_pending <= 0; axw(`ADDR_ARITH_STATUS, 32'h0); $display("t_regs done");
    endtask
    task automatic t_alu();
        logic [31:0] mx [7] = '{32'hfffffffe, 32'h1fffe, 32'hffff0001, 32'hffff0001, 32'hffffffe1,
                                32'h1effe1, 32'hfe01};
        logic [15:0] mb [7] = '{16'h2, 16'h2, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h34ff};
        op(`OP_ADD, 32'h7fff, 16'h1, 32'h8000, 1); axr(`ADDR_ARITH_STATUS, `AXI_RESP_OKAY);
        chk("add flags", rd, 32'h10c);
        src_is_mem <= 1; dst_is_mem <= 1; op(`OP_SUB, 32'h5, 16'h5, 32'h0, 1);
        axr(`ADDR_ARITH_STATUS, `AXI_RESP_OKAY); chk("sub flags", rd, 32'h103);
        dst_is_mem <= 0; shift_amount <= 4'hf;
        op(`OP_ASR, 32'h8000, 16'h0, 32'h0, 1);
        src_is_mem <= 0; op_byte <= 1; op(`OP_ADD, 32'h12ff, 16'h1, 32'h1200, 1);
        axr(`ADDR_ARITH_STATUS, `AXI_RESP_OKAY); chk("byte flags", rd, 32'h103);
        op_byte <= 0; op(`OP_XOR, 32'hf0f0, 16'hff00, 32'h0ff0, 1);
        op(`OP_ASR, 32'h8000, 16'h0, 32'hffff, 1);
        op(`OP_SL, 32'h1, 16'h0, 32'h8000, 1);
        op(`OP_LSR, 32'h8000, 16'h0, 32'h1, 1);
        op_long <= 1;
        for (int i = 0; i < 7; i++) begin
            mul_mode <= i[2:0]; op(`OP_MUL, 32'hffff, mb[i], mx[i], 1);
        end
        op_signed <= 0; op(`OP_DIV, 32'h10000, 16'h3, 32'h15555, 19);
        @(negedge aclk); chk("quotient reg", m.r[0], 16'h5555);
        @(posedge aclk); op_long <= 0; op_signed <= 1;
        op(`OP_DIV, 32'hfffffff9, 16'h2, 32'hfffffffd, 19);
        $display("t_alu done");
    endtask
    task automatic t_abort();
        int n = 0;
        op_code <= `OP_DIV; op_start <= 1;
        for (int i = 0; i < 30; i++) begin
            @(posedge aclk); op_start <= i == 2; interrupt_break <= i > 5;
            if (i == 1) op_code <= `OP_ADD;
            @(negedge aclk); n += op_done;
        end
        chk("aborted done", n, 0);
        chk("busy", div_busy, 1'b0);
        $display("t_abort done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_regs();
        t_alu();
        t_abort();
        conclude();
    end
endmodule // test_cpu_arith_datapath
`default_nettype wire
